// *** src/cfpsi_core.sv ***
// Core special-function logic: peripheral flags and enables, reset cause
// bits, program counter with high latch, return stack and indirect access.
// Assumes the register bus, the sequencer and all event sources share clock.
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps

module cfpsi_core (
  input  wire logic                    clock,         // 100 MHz clock
  input  wire logic                    rst,           // Synchronous reset, active high
  input  wire logic                    por_cause,     // Held with rst on power-on reset
  input  wire logic                    bor_cause,     // Held with rst on brown-out reset
  input  wire logic                    brownout_circuit_enable, // Configuration bit
  input  wire cfpsi_pkg::cfpsi_bus_t   bus,           // Register access
  output logic [cfpsi_pkg::DATA_W-1:0] rdata,         // Read data, cycle after rd
  input  wire cfpsi_pkg::cfpsi_events_t events,       // Peripheral event pulses
  input  wire cfpsi_pkg::cfpsi_ccp_mode_t ccp_mode,   // Capture/compare unit mode
  input  wire cfpsi_pkg::cfpsi_flow_t  flow,          // Sequencer command
  output logic [cfpsi_pkg::PC_W-1:0]   pc,            // Program counter
  output logic                         periph_irq,    // Peripheral request to core
  output logic                         core_irq       // Request gated by global enable
);

  logic [7:0]                  flags_one_q;
  logic [7:0]                  flags_two_q;
  logic [7:0]                  enables_one_q;
  logic [7:0]                  enables_two_q;
  logic [7:0]                  irq_ctrl_q;
  logic [7:0]                  pointer_q;
  logic                        bank_q;
  logic [7:0]                  latch_q;
  logic                        poweron_q;
  logic                        brownout_status_n_q;
  logic [cfpsi_pkg::PC_W-1:0]  pc_q;
  logic [cfpsi_pkg::PC_W-1:0]  pc_d;
  logic [cfpsi_pkg::PC_W-1:0]  stack_q [cfpsi_pkg::DEPTH];
  logic [cfpsi_pkg::SP_W-1:0]  sp_q;
  logic [7:0]                  rdata_q;
  logic [7:0]                  rdata_d;
  logic [7:0]                  set_one;
  logic [7:0]                  set_two;
  logic [cfpsi_pkg::ADDR_W-1:0] eff_addr;
  logic                        self_ref;
  logic                        wr_ok;
  logic                        push;
  logic                        pop;
  logic [cfpsi_pkg::PC_W-1:0]  push_val;
  logic [cfpsi_pkg::SP_W-1:0]  top_idx;

  // Indirect port access resolves through bank bit and pointer
  always_comb begin
    if (bus.addr[cfpsi_pkg::LOW_W-1:0] == cfpsi_pkg::A_INDIRECT_PORT) begin
      eff_addr = {bank_q, pointer_q};
    end else begin
      eff_addr = bus.addr;
    end
  end

  // Pointer aimed at the port itself has no target
  assign self_ref = (eff_addr[cfpsi_pkg::LOW_W-1:0] == cfpsi_pkg::A_INDIRECT_PORT);
  assign wr_ok    = bus.wr && !self_ref;

  function automatic logic hit_low(input logic [8:0] a, input logic [6:0] off);
    hit_low = (a[6:0] == off);
  endfunction : hit_low

  // Event to flag bit mapping
  always_comb begin
    set_one = cfpsi_pkg::ZERO_BYTE;
    set_two = cfpsi_pkg::ZERO_BYTE;
    set_one[cfpsi_pkg::B_ADC]    = events.adc_done;
    set_one[cfpsi_pkg::B_SERIAL] = events.serial_done;
    set_one[cfpsi_pkg::B_CCP]    =
      (events.ccp_capture && ccp_mode == cfpsi_pkg::CFPSI_CCP_CAPTURE) ||
      (events.ccp_compare && ccp_mode == cfpsi_pkg::CFPSI_CCP_COMPARE);
    set_one[cfpsi_pkg::B_TIMER2] = events.timer2_match;
    set_one[cfpsi_pkg::B_TIMER1] = events.timer1_overflow;
    set_two[cfpsi_pkg::B_EEPROM] = events.eeprom_write_done;
  end

  // Flag bits: an event in the clearing cycle still sets the flag
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      always_ff @(posedge clock) begin
        if (rst || !cfpsi_pkg::M_FLAGS_ONE[gi]) begin
          flags_one_q[gi] <= 1'b0;
        end else if (set_one[gi]) begin
          flags_one_q[gi] <= 1'b1;
        end else if (wr_ok && eff_addr == cfpsi_pkg::A_FLAGS_ONE) begin
          flags_one_q[gi] <= bus.wdata[gi];
        end
      end
      always_ff @(posedge clock) begin
        if (rst || !cfpsi_pkg::M_FLAGS_TWO[gi]) begin
          flags_two_q[gi] <= 1'b0;
        end else if (set_two[gi]) begin
          flags_two_q[gi] <= 1'b1;
        end else if (wr_ok && eff_addr == cfpsi_pkg::A_FLAGS_TWO) begin
          flags_two_q[gi] <= bus.wdata[gi];
        end
      end
    end
  endgenerate

  // Enable and control registers
  always_ff @(posedge clock) begin
    if (rst) begin
      enables_one_q <= cfpsi_pkg::ZERO_BYTE;
      enables_two_q <= cfpsi_pkg::ZERO_BYTE;
      irq_ctrl_q    <= cfpsi_pkg::ZERO_BYTE;
    end else if (wr_ok) begin
      if (eff_addr == cfpsi_pkg::A_ENABLES_ONE) begin
        enables_one_q <= bus.wdata & cfpsi_pkg::M_FLAGS_ONE;
      end
      if (eff_addr == cfpsi_pkg::A_ENABLES_TWO) begin
        enables_two_q <= bus.wdata & cfpsi_pkg::M_FLAGS_TWO;
      end
      if (hit_low(eff_addr, cfpsi_pkg::A_IRQ_CONTROL)) begin
        irq_ctrl_q <= bus.wdata & cfpsi_pkg::M_IRQ_CTRL;
      end
    end
  end

  // Pointer, bank select and high latch; stack actions leave the latch alone
  always_ff @(posedge clock) begin
    if (rst) begin
      pointer_q <= cfpsi_pkg::ZERO_BYTE;
      bank_q    <= 1'b0;
      latch_q   <= cfpsi_pkg::ZERO_BYTE;
    end else if (wr_ok) begin
      if (hit_low(eff_addr, cfpsi_pkg::A_POINTER)) begin
        pointer_q <= bus.wdata;
      end
      if (hit_low(eff_addr, cfpsi_pkg::A_BANK_SELECT)) begin
        bank_q <= bus.wdata[cfpsi_pkg::B_BANK];
      end
      if (hit_low(eff_addr, cfpsi_pkg::A_PC_LATCH)) begin
        latch_q <= {3'h0, bus.wdata[cfpsi_pkg::LATCH_HI:0]};
      end
    end
  end

  // Reset cause bits: cleared by their reset, set by software
  always_ff @(posedge clock) begin
    if (rst) begin
      if (por_cause) begin
        poweron_q           <= 1'b0;
        brownout_status_n_q <= 1'b0;
      end else if (bor_cause && brownout_circuit_enable) begin
        // A disabled brown-out circuit cannot cause this reset
        brownout_status_n_q <= 1'b0;
      end
    end else if (wr_ok && eff_addr == cfpsi_pkg::A_RESET_STATUS) begin
      poweron_q           <= bus.wdata[cfpsi_pkg::B_POWERON];
      brownout_status_n_q <= bus.wdata[cfpsi_pkg::B_BROWNOUT];
    end
  end

  // Stack push and pop requests
  assign push     = flow.call || flow.irq_branch;
  assign pop      = flow.ret && !push;
  assign push_val = flow.call ? pc_q + cfpsi_pkg::PC_ONE : pc_q;
  assign top_idx  = sp_q - cfpsi_pkg::SP_ONE;

  // Program counter next value; a low byte write wins over flow commands
  always_comb begin
    pc_d = pc_q;
    if (wr_ok && hit_low(eff_addr, cfpsi_pkg::A_PC_LOW)) begin
      pc_d = {latch_q[cfpsi_pkg::LATCH_HI:0], bus.wdata};
    end else if (flow.irq_branch) begin
      pc_d = cfpsi_pkg::IRQ_VECTOR;
    end else if (flow.call || flow.jump) begin
      pc_d = {latch_q[cfpsi_pkg::LATCH_HI:cfpsi_pkg::LATCH_PAGE], flow.target};
    end else if (pop) begin
      pc_d = stack_q[top_idx];
    end else if (flow.advance) begin
      pc_d = pc_q + cfpsi_pkg::PC_ONE;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pc_q <= '0;
    end else begin
      pc_q <= pc_d;
    end
  end

  // Circular stack: the pointer wraps, the oldest entry is overwritten
  always_ff @(posedge clock) begin
    if (rst) begin
      sp_q <= '0;
    end else if (push) begin
      sp_q <= sp_q + cfpsi_pkg::SP_ONE;
    end else if (pop) begin
      sp_q <= top_idx;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      stack_q[sp_q] <= push_val;
    end
  end

  // Read mux; upper counter bits and stack pointer are never visible
  always_comb begin
    rdata_d = cfpsi_pkg::ZERO_BYTE;
    if (self_ref) begin
      rdata_d = cfpsi_pkg::ZERO_BYTE;
    end else if (hit_low(eff_addr, cfpsi_pkg::A_PC_LOW)) begin
      rdata_d = pc_q[7:0];
    end else if (hit_low(eff_addr, cfpsi_pkg::A_BANK_SELECT)) begin
      rdata_d[cfpsi_pkg::B_BANK] = bank_q;
    end else if (hit_low(eff_addr, cfpsi_pkg::A_POINTER)) begin
      rdata_d = pointer_q;
    end else if (hit_low(eff_addr, cfpsi_pkg::A_PC_LATCH)) begin
      rdata_d = latch_q;
    end else if (hit_low(eff_addr, cfpsi_pkg::A_IRQ_CONTROL)) begin
      rdata_d = irq_ctrl_q;
    end else begin
      case (eff_addr)
        cfpsi_pkg::A_FLAGS_ONE:    rdata_d = flags_one_q;
        cfpsi_pkg::A_FLAGS_TWO:    rdata_d = flags_two_q;
        cfpsi_pkg::A_ENABLES_ONE:  rdata_d = enables_one_q;
        cfpsi_pkg::A_ENABLES_TWO:  rdata_d = enables_two_q;
        cfpsi_pkg::A_RESET_STATUS: begin
          rdata_d[cfpsi_pkg::B_POWERON]  = poweron_q;
          rdata_d[cfpsi_pkg::B_BROWNOUT] = brownout_status_n_q;
        end
        default:                   rdata_d = cfpsi_pkg::ZERO_BYTE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_q <= cfpsi_pkg::ZERO_BYTE;
    end else if (bus.rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= cfpsi_pkg::ZERO_BYTE;
    end
  end

  assign rdata = rdata_q;
  assign pc    = pc_q;

  // Interrupt request: any flag with its enable, gated by peripheral enable
  assign periph_irq = irq_ctrl_q[cfpsi_pkg::B_PERIPHERAL_IRQ_ENABLE] &&
                      (|(flags_one_q & enables_one_q) ||
                       |(flags_two_q & enables_two_q));
  assign core_irq   = periph_irq && irq_ctrl_q[cfpsi_pkg::B_GIE];

endmodule : cfpsi_core

// *** include/cfpsi_pkg.sv ***
// Package for the core flag, program counter, stack and indirect block.
// Assumes one 100 MHz clock shared with the CPU sequencer and all event sources.
package cfpsi_pkg;

  localparam int unsigned ADDR_W  = 9;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned PC_W    = 13;
  localparam int unsigned TGT_W   = 11;
  localparam int unsigned DEPTH   = 8;
  localparam int unsigned SP_W    = 3;
  localparam int unsigned LOW_W   = 7;

  // Registers mirrored in every bank, decoded on the low seven address bits
  localparam logic [6:0] A_INDIRECT_PORT = 7'h00;
  localparam logic [6:0] A_PC_LOW        = 7'h02;
  localparam logic [6:0] A_BANK_SELECT   = 7'h03;
  localparam logic [6:0] A_POINTER       = 7'h04;
  localparam logic [6:0] A_PC_LATCH      = 7'h0a;
  localparam logic [6:0] A_IRQ_CONTROL   = 7'h0b;
  // Registers decoded on the full address
  localparam logic [8:0] A_FLAGS_ONE     = 9'h00c;
  localparam logic [8:0] A_FLAGS_TWO     = 9'h00d;
  localparam logic [8:0] A_ENABLES_ONE   = 9'h08c;
  localparam logic [8:0] A_ENABLES_TWO   = 9'h08d;
  localparam logic [8:0] A_RESET_STATUS  = 9'h08e;

  // Implemented-bit masks; other bits read as zero and ignore writes
  localparam logic [7:0] M_FLAGS_ONE  = 8'h4f;
  localparam logic [7:0] M_FLAGS_TWO  = 8'h10;
  localparam logic [7:0] M_IRQ_CTRL   = 8'hc0;
  localparam logic [7:0] M_STATUS     = 8'h03;

  localparam int unsigned B_ADC       = 6;
  localparam int unsigned B_SERIAL    = 3;
  localparam int unsigned B_CCP       = 2;
  localparam int unsigned B_TIMER2    = 1;
  localparam int unsigned B_TIMER1    = 0;
  localparam int unsigned B_EEPROM    = 4;
  localparam int unsigned B_GIE       = 7;
  localparam int unsigned B_PERIPHERAL_IRQ_ENABLE      = 6;
  localparam int unsigned B_BANK      = 7;
  localparam int unsigned B_POWERON   = 1;
  localparam int unsigned B_BROWNOUT  = 0;
  localparam int unsigned LATCH_HI    = 4;
  localparam int unsigned LATCH_PAGE  = 3;

  localparam logic [12:0] IRQ_VECTOR  = 13'h0004;
  localparam logic [12:0] PC_ONE      = 13'h0001;
  localparam logic [2:0]  SP_ONE      = 3'h1;
  localparam logic [7:0]  ZERO_BYTE   = 8'h00;

  typedef enum logic [1:0] {
    CFPSI_CCP_CAPTURE = 2'h0,
    CFPSI_CCP_COMPARE = 2'h1,
    CFPSI_CCP_PWM     = 2'h2,
    CFPSI_CCP_OFF     = 2'h3
  } cfpsi_ccp_mode_t;

  // One-cycle event pulses from the peripherals
  typedef struct packed {
    logic adc_done;
    logic serial_done;
    logic ccp_capture;
    logic ccp_compare;
    logic timer2_match;
    logic timer1_overflow;
    logic eeprom_write_done;
  } cfpsi_events_t;

  // One-cycle program flow commands from the CPU sequencer
  typedef struct packed {
    logic              advance;
    logic              jump;
    logic              call;
    logic              ret;
    logic              irq_branch;
    logic [TGT_W-1:0]  target;
  } cfpsi_flow_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } cfpsi_bus_t;

endpackage : cfpsi_pkg

// *** test/cfpsi_partner.sv ***
// Event source model: raises the requested event pulses after a short lag.
// Assumes the clock of the core block; requests come from the testbench.
`timescale 1ns/10ps

module cfpsi_partner (
  input  wire logic                     clock,  // Shared clock
  input  wire logic                     rst,    // Synchronous reset
  input  wire logic                     go,     // Start one burst
  input  wire logic [2:0]               lag,    // Cycles before the pulse
  input  wire cfpsi_pkg::cfpsi_events_t req,    // Events to raise
  output cfpsi_pkg::cfpsi_events_t      events  // One-cycle pulses
);
  logic [2:0]               cnt_q;
  logic                     busy_q;
  cfpsi_pkg::cfpsi_events_t pend_q;

  always_ff @(posedge clock) begin
    events <= '0;
    if (rst) begin
      busy_q <= 1'b0;
    end else if (go) begin
      busy_q <= 1'b1;
      cnt_q  <= lag;
      pend_q <= req;
    end else if (busy_q && cnt_q == 3'h0) begin
      events <= pend_q;
      busy_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end
endmodule : cfpsi_partner

// *** test/cfpsi_core_sva.sv ***
// Checker on the ports of the core block.
// Assumes one clock and the synchronous active-high reset.
`timescale 1ns/10ps

module cfpsi_core_sva (
  input wire logic                    clock,      // Clock
  input wire logic                    rst,        // Reset
  input wire cfpsi_pkg::cfpsi_bus_t   bus,        // Register access
  input wire logic [7:0]              rdata,      // Read data
  input wire cfpsi_pkg::cfpsi_flow_t  flow,       // Sequencer command
  input wire logic [12:0]             pc,         // Program counter
  input wire logic                    periph_irq, // Peripheral request
  input wire logic                    core_irq    // Gated request
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic pcl_wr;
  logic any_fl;
  assign pcl_wr = bus.wr && bus.addr[6:0] == cfpsi_pkg::A_PC_LOW;
  assign any_fl = flow.jump || flow.call || flow.ret || flow.irq_branch;

  a_rdata_idle_zero: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  a_core_irq_gated: assert property (core_irq |-> periph_irq)
    else $error("core request without peripheral request");
  a_pc_low_load: assert property (pcl_wr |=> pc[7:0] == $past(bus.wdata))
    else $error("pc low byte not loaded");
  a_pc_irq_vector: assert property (flow.irq_branch && !pcl_wr |=> pc == 13'h0004)
    else $error("interrupt branch not at vector");
  a_pc_call_target: assert property ((flow.jump || flow.call) && !flow.irq_branch
    && !pcl_wr |=> pc[10:0] == $past(flow.target))
    else $error("jump target not loaded");
  a_pc_advance_one: assert property (flow.advance && !any_fl && !pcl_wr
    |=> pc == $past(pc) + 13'h0001)
    else $error("advance not by one");
  a_pc_reset_clear: assert property ($fell(rst) |-> pc == 13'h0000)
    else $error("pc not cleared by reset");
  a_pc_hold_idle: assert property (!flow.advance && !any_fl && !pcl_wr |=> $stable(pc))
    else $error("pc moved without command");
endmodule : cfpsi_core_sva

bind cfpsi_core cfpsi_core_sva cfpsi_core_sva_inst (.clock(clock), .rst(rst), .bus(bus),
  .rdata(rdata), .flow(flow), .pc(pc), .periph_irq(periph_irq), .core_irq(core_irq));

// *** test/testbench.sv ***
// Self-checking bench: register bus tasks, sequencer commands, event model.
// Assumes the checker is bound to the core; reads are checked from a queue.
`timescale 1ns/10ps

module testbench;
  logic clock, rst, por_cause, bor_cause, brownout_circuit_enable, go, rd_q;
  cfpsi_pkg::cfpsi_bus_t      bus;
  cfpsi_pkg::cfpsi_events_t   events, req;
  cfpsi_pkg::cfpsi_ccp_mode_t ccp_mode;
  cfpsi_pkg::cfpsi_flow_t     flow;
  logic [7:0]  rdata, e1, e2;
  logic [12:0] pc, pm;
  logic [12:0] stk [8];
  logic [10:0] t;
  logic [2:0]  lag, sp;
  logic        periph_irq, core_irq;
  logic [7:0]  expq [$];
  int          n_fail, cmp_count, seed;

  cfpsi_core cfpsi_core_inst (.clock(clock), .rst(rst), .por_cause(por_cause),
    .bor_cause(bor_cause), .brownout_circuit_enable(brownout_circuit_enable), .bus(bus),
    .rdata(rdata), .events(events), .ccp_mode(ccp_mode), .flow(flow), .pc(pc),
    .periph_irq(periph_irq), .core_irq(core_irq));
  cfpsi_partner cfpsi_partner_inst (.clock(clock), .rst(rst), .go(go), .lag(lag),
    .req(req), .events(events));

  always #5 clock = ~clock;

  task automatic chk(input string n, input logic [12:0] e, input logic [12:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= {a, d, 2'b10};
    @(posedge clock);
    bus.wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    @(posedge clock);
    bus <= {a, 8'h00, 2'b01};
    expq.push_back(e);
    @(posedge clock);
    bus.rd <= 1'b0;
  endtask : rd

  task automatic fl(input logic [4:0] k, input logic [10:0] tg);
    @(posedge clock);
    flow <= {k, tg};
    @(posedge clock);
    flow <= '0;
    #1;
  endtask : fl

  task automatic ev(input logic [6:0] r);
    @(posedge clock);
    go  <= 1'b1;
    req <= r;
    lag <= 3'($random(seed)) & 3'h3;
    @(posedge clock);
    go <= 1'b0;
    repeat (7) @(posedge clock);
    #1;
  endtask : ev

  task automatic rs(input logic p, input logic b);
    @(posedge clock);
    rst       <= 1'b1;
    por_cause <= p;
    bor_cause <= b;
    repeat (3) @(posedge clock);
    rst       <= 1'b0;
    por_cause <= 1'b0;
    bor_cause <= 1'b0;
    #1;
  endtask : rs

  // Read data stand only in the cycle after the strobe
  always @(posedge clock) rd_q <= bus.rd;
  always @(negedge clock) begin
    if (rd_q === 1'b1) begin
      chk("rdata", {5'h00, expq.pop_front()}, {5'h00, rdata});
    end
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    close_out();
  end

  initial begin
    clock = 0;
    rst = 1;
    por_cause = 1;
    bor_cause = 0;
    brownout_circuit_enable = 1;
    bus = '0;
    flow = '0;
    go = 0;
    lag = 0;
    req = '0;
    ccp_mode = cfpsi_pkg::CFPSI_CCP_CAPTURE;
    seed = 32'hd265;
    sp = 3'h0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    por_cause <= 1'b0;
    rd(9'h00c, 8'h00);
    rd(9'h00d, 8'h00);
    rd(9'h08d, 8'h00);
    rd(9'h08e, 8'h00);
    wr(9'h00c, 8'hff);
    rd(9'h00c, 8'h4f);
    wr(9'h00d, 8'hff);
    rd(9'h00d, 8'h10);
    wr(9'h08d, 8'hff);
    rd(9'h08d, 8'h10);
    wr(9'h1f0, 8'hff);
    rd(9'h1f0, 8'h00);
    wr(9'h00c, 8'h00);
    rd(9'h00c, 8'h00);
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      for (int i = 0; i < 7; i++) begin
        ccp_mode <= cfpsi_pkg::cfpsi_ccp_mode_t'(m);
        e1 = (i == 6) ? 8'h40 : (i == 5) ? 8'h08 : (i == 2) ? 8'h02 : (i == 1) ? 8'h01 : 8'h00;
        if ((i == 4 && m == 0) || (i == 3 && m == 1)) e1 = 8'h04;
        e2 = (i == 0) ? 8'h10 : 8'h00;
        ev(7'h01 << i);
        rd(9'h00c, e1);
        rd(9'h00d, e2);
        wr(9'h00c, 8'h00);
        wr(9'h00d, 8'h00);
      end
    end
    $display("test events done");
    ev(7'h01);
    wr(9'h0d, 8'h00);
    ev(7'h01);
    chk("periph_irq", 13'h0000, {12'h000, periph_irq});
    wr(9'h0b, 8'h40);
    chk("periph_irq", 13'h0001, {12'h000, periph_irq});
    chk("core_irq", 13'h0000, {12'h000, core_irq});
    wr(9'h0b, 8'hc0);
    chk("core_irq", 13'h0001, {12'h000, core_irq});
    wr(9'h0d, 8'h00);
    chk("periph_irq", 13'h0000, {12'h000, periph_irq});
    wr(9'h08c, 8'hff);
    rd(9'h08c, 8'h4f);
    ev(7'h40);
    chk("periph_irq", 13'h0001, {12'h000, periph_irq});
    wr(9'h00c, 8'h00);
    chk("periph_irq", 13'h0000, {12'h000, periph_irq});
    wr(9'h0b, 8'h00);
    $display("test interrupt done");
    wr(9'h00a, 8'h1f);
    wr(9'h002, 8'h55);
    chk("pc", 13'h1f55, pc);
    rd(9'h002, 8'h55);
    t = 11'($random(seed));
    fl(5'h08, t);
    chk("pc", {2'b11, t}, pc);
    fl(5'h10, 11'h000);
    pm = {2'b11, t} + 13'h0001;
    chk("pc", pm, pc);
    wr(9'h00a, 8'h08);
    for (int i = 0; i < 9; i++) begin
      t = 11'($random(seed));
      stk[sp] = pm + 13'h0001;
      sp = sp + 3'h1;
      pm = {2'b01, t};
      fl(5'h04, t);
      chk("pc", pm, pc);
    end
    for (int i = 0; i < 9; i++) begin
      sp = sp - 3'h1;
      pm = stk[sp];
      fl(5'h02, 11'h000);
      chk("pc", pm, pc);
    end
    stk[sp] = pm;
    fl(5'h01, 11'h000);
    chk("pc", 13'h0004, pc);
    fl(5'h02, 11'h000);
    chk("pc", stk[sp], pc);
    rd(9'h00a, 8'h08);
    $display("test program counter done");
    wr(9'h08e, 8'h03);
    rd(9'h08e, 8'h03);
    rs(1'b0, 1'b0);
    chk("pc", 13'h0000, pc);
    rd(9'h08e, 8'h03);
    rs(1'b0, 1'b1);
    rd(9'h08e, 8'h02);
    rs(1'b1, 1'b0);
    rd(9'h08e, 8'h00);
    $display("test reset cause done");
    wr(9'h004, 8'h8d);
    wr(9'h000, 8'hff);
    rd(9'h08d, 8'h10);
    rd(9'h000, 8'h10);
    wr(9'h003, 8'h80);
    rd(9'h000, 8'h00);
    wr(9'h004, 8'h80);
    wr(9'h000, 8'hff);
    rd(9'h000, 8'h00);
    $display("test indirect done");
    repeat (3) @(posedge clock);
    close_out();
  end
endmodule : testbench
